//--- rtl/pmbus_mask_pkg.sv
// Purpose: Shared constants for the alert mask and output format registers
// Assumes: Byte-wide command interface from an upstream PMBus engine
// Notes: Reset values stand in for nonvolatile defaults
package pmbus_mask_pkg;
  // ==========================================================
  // Command codes
  // ==========================================================
  localparam logic [7:0] CMD_ALERT_MASK = 8'h1B; // Shared mask command
  localparam logic [7:0] CMD_VOUT_FORMAT = 8'h20; // Output format command
  localparam logic [7:0] SEL_OTHER_GROUP = 8'h7F; // Other status group selector
  localparam logic [7:0] SEL_VENDOR_GROUP = 8'h80; // Vendor status group selector
  // ==========================================================
  // Field layout
  // ==========================================================
  localparam int FIRST_ALERT_BIT = 0;
  localparam int POR_BIT = 7;
  localparam int SELF_BIT = 6;
  localparam int RESET_EV_BIT = 3;
  localparam int BACKCH_BIT = 2;
  localparam int SYNC_BIT = 1;
  localparam int REL_BIT = 7;
  localparam int MODE_HI = 6;
  localparam int MODE_LO = 5;
  localparam int PARAM_HI = 4;
  localparam int PARAM_LO = 0;
  // Writable vendor mask bits
  localparam logic [7:0] VENDOR_WR_MASK = 8'hCE;
  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] OTHER_RESET = 8'h01;
  localparam logic [7:0] VENDOR_RESET = 8'hCE; // All writable bits masked
  localparam logic [1:0] MODE_LINEAR = 2'h0;
  localparam logic REL_RESET = 1'b0;
  localparam logic [4:0] PARAM_RESET = 5'h14; // Exponent -12
  localparam logic signed [4:0] EXP_MAX = -5'sd4;
  localparam logic signed [4:0] EXP_MIN = -5'sd12;
endpackage

//--- rtl/alert_gate.sv
// Purpose: Combines status conditions with their mask bits into one alert level
// Assumes: Conditions and masks are on the system clock
// Notes: Output registered so the alert pin is glitch free
module alert_gate #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] cond_i,
  input wire logic [WIDTH-1:0] mask_i,
  output logic alert_o
);
  // ==========================================================
  // Gating per bit
  // ==========================================================
  logic [WIDTH-1:0] pass;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      assign pass[g] = cond_i[g] & ~mask_i[g];
    end
  endgenerate
  // Registered alert request
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      alert_o <= 1'b0;
    end else begin
      alert_o <= |pass;
    end
  end
endmodule

//--- rtl/pmbus_alert_mask_output_voltage_format.sv
// Purpose: Alert mask bytes for other and vendor groups, output format byte
// Assumes: Upstream PMBus engine decodes frames into byte strobes
// Notes: Conversion of dependent output values is signalled, done elsewhere
//
// Summary of operation
// - Other mask bit 0 reads fixed one
// - Vendor mask selected by 1Bh with 80h
// - Vendor mask zero allows, one blocks alert
// - Unmasked self check may alert at power-up
// - Unmasked sync may briefly alert on enable
// - Format byte: flag, mode, parameter fields
// - Flag zero absolute, one relative format
// - Mode field read-only, resets linear
// - Exponent two's complement, -4 to -12
// - Format writable only while conversion disabled
// - Format change triggers stored value conversion
module pmbus_alert_mask_output_voltage_format (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic wr_i,                 // One-cycle write strobe
  input wire logic rd_i,                 // One-cycle read strobe
  input wire logic [7:0] cmd_i,          // Command code
  input wire logic [7:0] sel_i,          // Group selector, first data byte
  input wire logic [7:0] wdata_i,        // Write data byte
  input wire logic conv_enable_i,        // Output conversion enabled
  input wire logic [7:0] vendor_status_i, // Vendor status conditions
  output logic [7:0] rdata_o,            // Read data byte
  output logic rvalid_o,                 // Read data valid pulse
  output logic cmd_error_o,              // Unsupported access pulse
  output logic alert_o,                  // Alert request, active high
  output logic relative_format_flag_o,   // Current format flag
  output logic [4:0] exponent_o,         // Current exponent
  output logic format_change_o           // Convert stored values pulse
);
  // ==========================================================
  // Storage
  // ==========================================================
  logic [7:0] vendor_mask; // Writable vendor mask bits
  logic relative_format_flag; // Format flag
  logic [4:0] exponent; // Exponent parameter
  logic hit_vendor; // Vendor mask addressed
  logic hit_other; // Other mask addressed
  logic hit_format; // Format byte addressed
  logic exp_ok; // Written exponent within range
  logic mode_ok; // Written mode field is linear
  logic fmt_accept; // Format write taken this edge
  logic [7:0] format_byte; // Assembled format byte
  // Decode by if chain
  always_comb begin
    // Nothing addressed by default
    hit_vendor = 1'b0;
    hit_other = 1'b0;
    hit_format = 1'b0;
    if (cmd_i == pmbus_mask_pkg::CMD_ALERT_MASK && sel_i == pmbus_mask_pkg::SEL_VENDOR_GROUP) begin
      hit_vendor = 1'b1;
    end else if (cmd_i == pmbus_mask_pkg::CMD_ALERT_MASK && sel_i == pmbus_mask_pkg::SEL_OTHER_GROUP) begin
      // Other group, read-only byte
      hit_other = 1'b1;
    end else if (cmd_i == pmbus_mask_pkg::CMD_VOUT_FORMAT) begin
      // Format byte, selector ignored
      hit_format = 1'b1;
    end
  end
  assign exp_ok = ($signed(wdata_i[pmbus_mask_pkg::PARAM_HI:pmbus_mask_pkg::PARAM_LO]) <= pmbus_mask_pkg::EXP_MAX) &&
                  ($signed(wdata_i[pmbus_mask_pkg::PARAM_HI:pmbus_mask_pkg::PARAM_LO]) >= pmbus_mask_pkg::EXP_MIN);
  // only the linear mode code is taken
  assign mode_ok = (wdata_i[pmbus_mask_pkg::MODE_HI:pmbus_mask_pkg::MODE_LO] == pmbus_mask_pkg::MODE_LINEAR);
  // one qualifier shared by store, pulse and error
  assign fmt_accept = wr_i && hit_format && !conv_enable_i && exp_ok && mode_ok;
  // byte layout with fixed linear mode
  assign format_byte = {relative_format_flag, pmbus_mask_pkg::MODE_LINEAR, exponent};
  // ==========================================================
  // Vendor mask register
  // ==========================================================
  // Only writable bits stored; unsupported bits stay zero
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      vendor_mask <= pmbus_mask_pkg::VENDOR_RESET;
    end else if (wr_i && hit_vendor) begin
      vendor_mask <= wdata_i & pmbus_mask_pkg::VENDOR_WR_MASK;
    end
  end
  // ==========================================================
  // Format register
  // ==========================================================
  // Rejected writes leave the old value so stored values stay coherent
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      relative_format_flag <= pmbus_mask_pkg::REL_RESET;
      exponent <= pmbus_mask_pkg::PARAM_RESET;
    end else if (fmt_accept) begin
      relative_format_flag <= wdata_i[pmbus_mask_pkg::REL_BIT];
      exponent <= wdata_i[pmbus_mask_pkg::PARAM_HI:pmbus_mask_pkg::PARAM_LO];
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      format_change_o <= 1'b0;
    end else begin
      // Same-value writes need no conversion downstream
      format_change_o <= fmt_accept && (wdata_i != format_byte);
    end
  end
  // flag to downstream interpreter
  // Outputs lag storage by one edge
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      relative_format_flag_o <= pmbus_mask_pkg::REL_RESET;
      exponent_o <= pmbus_mask_pkg::PARAM_RESET;
    end else begin
      relative_format_flag_o <= relative_format_flag;
      exponent_o <= exponent;
    end
  end
  // ==========================================================
  // Read path and errors
  // ==========================================================
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      // Pulse follows every read strobe
      rvalid_o <= rd_i;
      if (rd_i && hit_vendor) begin
        // Vendor mask, reserved bits already zero
        rdata_o <= vendor_mask;
      end else if (rd_i && hit_other) begin
        rdata_o <= pmbus_mask_pkg::OTHER_RESET;
      end else if (rd_i && hit_format) begin
        rdata_o <= format_byte;
      end else if (rd_i) begin
        // Unmapped read answers zero
        rdata_o <= 8'h00;
      end
    end
  end
  // Flags writes that were refused, and reads or writes that were unmapped
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cmd_error_o <= 1'b0;
    end else begin
      // Read-only other byte, refused format write, unknown target
      cmd_error_o <= (wr_i && hit_other) ||
        (wr_i && hit_format && !fmt_accept) ||
        ((wr_i || rd_i) && !hit_vendor && !hit_other && !hit_format);
    end
  end
  // ==========================================================
  // Alert gating
  // ==========================================================
  // mask gates alert
  // sync unmasked may fire
  // Reserved status bits cut before the gate
  alert_gate #(.WIDTH(8)) u_gate (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .cond_i(vendor_status_i & pmbus_mask_pkg::VENDOR_WR_MASK),
    .mask_i(vendor_mask),
    .alert_o(alert_o)
  );
  // ==========================================================
  // Checks
  // ==========================================================
  // masked conditions stay quiet
  mask_block_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ((vendor_status_i & ~vendor_mask & pmbus_mask_pkg::VENDOR_WR_MASK) == 8'h00) |=> !alert_o)
    else $error("alert with all conditions masked");
  mask_pass_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ((vendor_status_i & ~vendor_mask & pmbus_mask_pkg::VENDOR_WR_MASK) != 8'h00) |=> alert_o)
    else $error("unmasked condition did not alert");
  other_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (rd_i && hit_other) |=> (rvalid_o && rdata_o == 8'h01))
    else $error("other mask read not one");
  vendor_rsvd_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (rd_i && hit_vendor) |=> ((rdata_o & 8'h31) == 8'h00))
    else $error("vendor reserved bits set");
  mode_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (rd_i && hit_format) |=> (rdata_o[6:5] == 2'h0))
    else $error("mode field not linear");
  locked_fmt_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_i && hit_format && conv_enable_i) |=> ($stable(exponent) && $stable(relative_format_flag) && cmd_error_o))
    else $error("format changed while conversion on");
  exp_range_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ($signed(exponent) <= pmbus_mask_pkg::EXP_MAX) && ($signed(exponent) >= pmbus_mask_pkg::EXP_MIN))
    else $error("exponent out of range");
  fmt_change_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    format_change_o == !$stable({relative_format_flag, exponent}))
    else $error("format change pulse mismatch");
  flag_out_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (rd_i && hit_format) |=> (rdata_o[7] == relative_format_flag_o && rdata_o[4:0] == exponent_o))
    else $error("flag output lags");
  other_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_i && hit_other) |=> cmd_error_o)
    else $error("other mask write not refused");
  vendor_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_i && hit_vendor) |=> (vendor_mask == ($past(wdata_i) & pmbus_mask_pkg::VENDOR_WR_MASK)))
    else $error("vendor mask write lost");
  fmt_store_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    fmt_accept |=> (relative_format_flag == $past(wdata_i[pmbus_mask_pkg::REL_BIT]) &&
      exponent == $past(wdata_i[pmbus_mask_pkg::PARAM_HI:pmbus_mask_pkg::PARAM_LO])))
    else $error("format write not stored");
  bad_mode_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_i && hit_format && !mode_ok) |=> (cmd_error_o && $stable(exponent) && !format_change_o))
    else $error("non-linear mode accepted");
endmodule

//--- sim/pmbus_host_model.sv
// Purpose: Host controller model issuing byte accesses
// Assumes: Strobes sampled on the rising edge
// Notes: Released request lines show inverted bytes
module pmbus_host_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] rdata_i,
  input wire logic cmd_error_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] cmd_o,
  output logic [7:0] sel_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // Idle
  // ======
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    {cmd_o, sel_o, wdata_o} = 24'h000000;
  end
  // ======
  // Access
  // ======
  // selector as first byte
  task automatic xfer(input logic w, input logic [7:0] c, s, d, output logic [7:0] rd, output logic er);
    @(posedge clk_sys_i);
    wr_o <= w;
    rd_o <= ~w;
    {cmd_o, sel_o, wdata_o} <= {c, s, d};
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    // Stale bytes must never look valid
    {cmd_o, sel_o, wdata_o} <= ~{c, s, d};
    #1;
    rd = rdata_i;
    er = cmd_error_i;
  endtask
endmodule

//--- sim/testbench.sv
// Purpose: Self-checking bench for mask and format registers
// Assumes: Host model drives one access at a time
// Notes: Expected values come from the register layout
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, reset_i, wr_i, rd_i, conv_enable_i, rvalid_o, cmd_error_o, alert_o, flag_o, format_change_o;
  logic [7:0] cmd_i, sel_i, wdata_i, vendor_status_i, rdata_o, rd;
  logic [4:0] exponent_o;
  logic er;
  int num_errors = 0;
  int cmp_count = 0;
  logic [7:0] bad [4] = '{8'h14, 8'hBC, 8'h9D, 8'h93}; // Refused format bytes
  pmbus_alert_mask_output_voltage_format i_pmbus_alert_mask_output_voltage_format (.clk_sys_i, .reset_i, .wr_i, .rd_i, .cmd_i,
    .sel_i, .wdata_i, .conv_enable_i, .vendor_status_i, .rdata_o, .rvalid_o, .cmd_error_o, .alert_o,
    .relative_format_flag_o(flag_o), .exponent_o, .format_change_o);
  pmbus_host_model i_host (.clk_sys_i, .rdata_i(rdata_o), .cmd_error_i(cmd_error_o), .wr_o(wr_i),
    .rd_o(rd_i), .cmd_o(cmd_i), .sel_o(sel_i), .wdata_o(wdata_i));
  // ======
  // Helpers
  // ======
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] c, s, d);
    i_host.xfer(w, c, s, d, rd, er);
  endtask
  task automatic final_report();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ======
  // Scenarios
  // ======
  // Reset values and read pulse timing
  task automatic t_reset();
    acc(0, 8'h1B, 8'h7F, 8'h00);
    check("other", rd, 8'h01);
    check("rvalid", 8'(rvalid_o), 8'h01);
    @(posedge clk_sys_i) #1;
    check("rvalid end", 8'(rvalid_o), 8'h00);
    acc(0, 8'h1B, 8'h80, 8'h00);
    check("vendor", rd, 8'hCE);
    acc(0, 8'h20, 8'h00, 8'h00);
    check("format", rd, 8'h14);
    check("exp", 8'(exponent_o), 8'h14);
    check("flag", 8'(flag_o), 8'h00);
    check("alert idle", 8'(alert_o), 8'h00);
  endtask
  // Mask bytes: refused, unmapped and written accesses
  task automatic t_masks();
    acc(1, 8'h1B, 8'h7F, 8'h00);
    check("other wr err", 8'(er), 8'h01);
    acc(0, 8'h1B, 8'h7F, 8'h00);
    check("other kept", rd, 8'h01);
    acc(0, 8'h1B, 8'h55, 8'h00);
    check("bad sel err", 8'(er), 8'h01);
    check("bad sel data", rd, 8'h00);
    acc(1, 8'h1B, 8'h80, 8'hFF);
    check("vendor wr err", 8'(er), 8'h00);
    acc(0, 8'h1B, 8'h80, 8'h00);
    check("vendor ff", rd, 8'hCE);
    acc(1, 8'h1B, 8'h80, 8'h00);
    acc(0, 8'h1B, 8'h80, 8'h00);
    check("vendor 00", rd, 8'h00);
  endtask
  // Alert gating per status bit
  task automatic t_alert();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys_i) vendor_status_i <= 8'h01 << i;
      @(posedge clk_sys_i) #1;
      check("alert bit", 8'(alert_o), 8'(8'hCE >> i) & 8'h01);
    end
    acc(1, 8'h1B, 8'h80, 8'h02);
    @(posedge clk_sys_i) vendor_status_i <= 8'h02;
    repeat (2) @(posedge clk_sys_i);
    #1;
    check("masked", 8'(alert_o), 8'h00);
    @(posedge clk_sys_i) vendor_status_i <= 8'h06;
    @(posedge clk_sys_i) #1;
    check("unmasked", 8'(alert_o), 8'h01);
    @(posedge clk_sys_i) vendor_status_i <= 8'h31;
    @(posedge clk_sys_i) #1;
    check("reserved", 8'(alert_o), 8'h00);
  endtask
  // Format byte accept, refuse and same-value writes
  task automatic t_format();
    acc(1, 8'h20, 8'h00, 8'h9C);
    check("fc err", 8'(er), 8'h00);
    check("fc", 8'(format_change_o), 8'h01);
    @(posedge clk_sys_i) #1;
    check("flag", 8'(flag_o), 8'h01);
    check("exp", 8'(exponent_o), 8'h1C);
    check("fc end", 8'(format_change_o), 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i) conv_enable_i <= (i == 0);
      acc(1, 8'h20, 8'h00, bad[i]);
      check("refuse err", 8'(er), 8'h01);
      check("refuse fc", 8'(format_change_o), 8'h00);
      acc(0, 8'h20, 8'h00, 8'h00);
      check("kept", rd, 8'h9C);
    end
    acc(1, 8'h20, 8'h00, 8'h14);
    @(posedge clk_sys_i) #1;
    check("abs flag", 8'(flag_o), 8'h00);
    check("abs exp", 8'(exponent_o), 8'h14);
    acc(1, 8'h20, 8'h00, 8'h14);
    check("same fc", 8'(format_change_o), 8'h00);
    check("same err", 8'(er), 8'h00);
  endtask
  // Reset in mid-run restores the defaults
  task automatic t_mid_reset();
    acc(1, 8'h20, 8'h00, 8'h9C);
    @(posedge clk_sys_i) reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    acc(0, 8'h1B, 8'h80, 8'h00);
    check("reset vendor", rd, 8'hCE);
    acc(0, 8'h20, 8'h00, 8'h00);
    check("reset format", rd, 8'h14);
    check("reset flag", 8'(flag_o), 8'h00);
    check("reset exp", 8'(exponent_o), 8'h14);
  endtask
  // ======
  // Main
  // ======
  initial begin
    reset_i = 1'b1;
    conv_enable_i = 1'b0;
    vendor_status_i = 8'h00;
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_reset();
    t_masks();
    t_alert();
    t_format();
    t_mid_reset();
    final_report();
  end
  // Run needs under a hundred cycles; far margin
  initial begin
    #20000;
    num_errors++;
    final_report();
  end
endmodule
